// [verilog/sdram_ctl_defines.svh]
// Purpose: Shared constants for the clock-gate / power control link
// Assumes: 40 MHz mclk, two banks selected by address bit 11
// Notes:   Timing counts derive from times in ns, except T_INIT_CYC, from a time in us, and T_MRD_CYC, given in cycles
`ifndef SDRAM_CTL_DEFINES_SVH
`define SDRAM_CTL_DEFINES_SVH
`define ADDR_W          12
`define BANK_BIT        11
`define AP_BIT          10
`define PALL_ADDR       12'h400
`define INIT_MODE       12'h020
`define COL_IGN_LO      8
`define COL_IGN_HI      9
`define MR_BL_LO        0
`define MR_BL_HI        2
`define MR_BT_BIT       3
`define MR_CL_LO        4
`define MR_CL_HI        6
`define MR_OPT_LO       8
`define MR_OPT_HI       11
`define BL_FULL_PAGE    3'h7
`define CLK_PERIOD_NS   25
`define T_RC_NS         70
`define T_RC_CYC        ((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RRD_NS        20
`define T_RRD_CYC       ((`T_RRD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RAS_NS        42
`define T_RAS_CYC       ((`T_RAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RCD_NS        20
`define T_RCD_CYC       ((`T_RCD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_MRD_CYC       2
`define T_INIT_US       100
`define T_INIT_CYC      (`T_INIT_US * 1000 / `CLK_PERIOD_NS)
`define REFRESH_INIT    2
`define ROW_CNT_W       11
`endif

// [verilog/sdram_ctl_pkg.sv]
// Purpose: Types shared by both ends of the link
// Assumes: Command pins follow the usual strobe encoding
// Notes:   Command value is {cs_n, ras_n, cas_n, we_n}
package sdram_ctl_pkg;
  typedef enum logic [3:0] {
    cmd_load     = 4'h0,
    cmd_refresh  = 4'h1,
    cmd_pre      = 4'h2,
    cmd_act      = 4'h3,
    cmd_write    = 4'h4,
    cmd_read     = 4'h5,
    cmd_burst_stop = 4'h6,
    cmd_nop      = 4'h7,
    cmd_desel    = 4'h8
  } cmd_t;
  typedef enum logic [2:0] {
    dev_idle     = 3'b000,
    dev_busy     = 3'b001,
    dev_suspend  = 3'b011,
    dev_self_ref = 3'b010,
    dev_sr_recov = 3'b110,
    dev_pdown    = 3'b111
  } dev_state_t;
  typedef enum logic [1:0] {
    bank_idle   = 2'b00,
    bank_active = 2'b01,
    bank_burst  = 2'b11,
    bank_burst_ap = 2'b10
  } bank_state_t;
endpackage

// [verilog/sdram_link_if.sv]
// Purpose: Pin-level link between memory controller and device model logic
// Assumes: Single clock mclk drives both ends
// Notes:   Data pins omitted; the block covers command and power control
`timescale 1ns/1ps
interface sdram_link_if;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [11:0] addr;
  logic [1:0]  dqm;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n,
                output we_n, output addr, output dqm);
  modport dev  (input cke, input cs_n, input ras_n, input cas_n,
                input we_n, input addr, input dqm);
endinterface

// [verilog/sdram_dev_end.sv]
// Purpose: Device end: command decode, bank states, power-down, self-refresh
// Assumes: Link pins come from logic on mclk, so no synchroniser is used
// Notes:   Bursts modelled as a counter; no data path
`timescale 1ns/1ps
`include "sdram_ctl_defines.svh"
module sdram_dev_end
  import sdram_ctl_pkg::*;
#(
  parameter int BURST_W = 9
) (
  input  wire logic           mclk,
  input  wire logic           rst,
  sdram_link_if.dev           link,
  output      logic [2:0]     burst_len,
  output      logic           burst_type,
  output      logic [2:0]     read_latency,
  output      logic [3:0]     mode_options,
  output      logic [`ROW_CNT_W-1:0] refresh_row,
  output      logic [7:0]     column_addr,
  output      logic           suspended,
  output      sdram_ctl_pkg::dev_state_t dev_state,
  output      logic [1:0]     bank_open,
  output      logic           illegal_cmd
);
  import sdram_ctl_pkg::*;

  dev_state_t                st_reg, st_next;
  bank_state_t               bank_reg [2], bank_next [2];
  logic [BURST_W-1:0]        bcnt_reg [2], bcnt_next [2];
  logic [`ADDR_W-1:0]        mode_reg, mode_next;
  logic [`ROW_CNT_W-1:0]     row_reg, row_next;
  logic [7:0]                col_reg, col_next;
  logic [3:0]                trc_reg, trc_next;
  logic                      cke_prev_reg;
  logic                      ill_reg, ill_next;
  cmd_t                      cmd;
  logic                      sel;
  logic                      all_idle;
  logic [BURST_W-1:0]        blen;

  assign cmd      = link.cs_n ? cmd_desel : cmd_t'({1'b0, link.ras_n, link.cas_n, link.we_n});
  assign sel      = link.addr[`BANK_BIT];
  assign all_idle = (bank_reg[0] == bank_idle) && (bank_reg[1] == bank_idle);

  always_comb begin
    case (mode_reg[`MR_BL_HI:`MR_BL_LO])
      3'h0:    blen = BURST_W'(1);
      3'h1:    blen = BURST_W'(2);
      3'h2:    blen = BURST_W'(4);
      3'h3:    blen = BURST_W'(8);
      default: blen = '1;
    endcase
  end

  always_comb begin
    st_next   = st_reg;
    bank_next = bank_reg;
    bcnt_next = bcnt_reg;
    mode_next = mode_reg;
    row_next  = row_reg;
    col_next  = col_reg;
    trc_next  = (trc_reg != 4'h0) ? trc_reg - 4'h1 : 4'h0;
    ill_next  = 1'b0;
    for (int b = 0; b < 2; b++) begin
      if (bank_reg[b] == bank_burst || bank_reg[b] == bank_burst_ap) begin
        if (bcnt_reg[b] <= BURST_W'(1)) begin
          bank_next[b] = (bank_reg[b] == bank_burst_ap) ? bank_idle : bank_active;
          bcnt_next[b] = '0;
        end else begin
          bcnt_next[b] = bcnt_reg[b] - BURST_W'(1);
        end
      end
    end
    case (st_reg)
      dev_self_ref: begin
        if (link.cke) begin
          st_next  = dev_sr_recov;
          trc_next = 4'(`T_RC_CYC);
          ill_next = (cmd != cmd_desel) && (cmd != cmd_nop);
        end
      end
      dev_sr_recov: begin
        if (cmd != cmd_desel && cmd != cmd_nop)
          ill_next = 1'b1;
        if (!link.cke)
          st_next = dev_pdown;
        else if (trc_reg <= 4'h1)
          st_next = dev_idle;
      end
      dev_pdown: begin
        if (link.cke)
          st_next = dev_idle;
      end
      dev_suspend: begin
        if (link.cke) begin
          st_next = dev_busy;
        end else begin
          bank_next = bank_reg;
          bcnt_next = bcnt_reg;
        end
      end
      default: begin
        // Commands decode only while the gate is high, and in busy only if it was also high in the prior cycle
        if (st_reg == dev_busy && !cke_prev_reg) begin
          bank_next = bank_reg;
          bcnt_next = bcnt_reg;
        end else if (all_idle && !link.cke && cmd == cmd_refresh) begin
          st_next = dev_self_ref;
        end else if (all_idle && !link.cke) begin
          st_next = dev_pdown;
        end else if (!link.cke) begin
          st_next = dev_suspend;
        end else begin
          case (cmd)
            cmd_load: begin
              if (all_idle)
                mode_next = link.addr;
              else
                ill_next = 1'b1;
            end
            cmd_refresh: begin
              if (all_idle)
                row_next = row_reg + `ROW_CNT_W'(1);
              else
                ill_next = 1'b1;
            end
            cmd_act: begin
              if (bank_reg[sel] == bank_idle)
                bank_next[sel] = bank_active;
              else
                ill_next = 1'b1;
            end
            cmd_pre: begin
              if (link.addr[`AP_BIT]) begin
                bank_next[0] = bank_idle;
                bank_next[1] = bank_idle;
              end else begin
                bank_next[sel] = bank_idle;
              end
            end
            cmd_read, cmd_write: begin
              if (bank_reg[sel] != bank_idle) begin
                bank_next[sel] = link.addr[`AP_BIT] ? bank_burst_ap : bank_burst;
                bcnt_next[sel] = blen;
                col_next       = link.addr[`COL_IGN_LO-1:0];
              end else begin
                ill_next = 1'b1;
              end
            end
            cmd_burst_stop: begin
              for (int b = 0; b < 2; b++)
                if (bank_reg[b] == bank_burst)
                  bank_next[b] = bank_active;
            end
            default: ;
          endcase
        end
        if (st_next == dev_idle || st_next == dev_busy)
          st_next = (bank_next[0] == bank_idle && bank_next[1] == bank_idle)
                    ? dev_idle : dev_busy;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg       <= dev_idle;
      bank_reg[0]  <= bank_idle;
      bank_reg[1]  <= bank_idle;
      bcnt_reg[0]  <= '0;
      bcnt_reg[1]  <= '0;
      mode_reg     <= '0;
      row_reg      <= '0;
      col_reg      <= '0;
      trc_reg      <= 4'h0;
      cke_prev_reg <= 1'b1;
      ill_reg      <= 1'b0;
    end else begin
      st_reg       <= st_next;
      bank_reg     <= bank_next;
      bcnt_reg     <= bcnt_next;
      mode_reg     <= mode_next;
      row_reg      <= row_next;
      col_reg      <= col_next;
      trc_reg      <= trc_next;
      cke_prev_reg <= link.cke;
      ill_reg      <= ill_next;
    end
  end

  assign burst_len    = mode_reg[`MR_BL_HI:`MR_BL_LO];
  assign burst_type   = mode_reg[`MR_BT_BIT];
  assign read_latency = mode_reg[`MR_CL_HI:`MR_CL_LO];
  assign mode_options = mode_reg[`MR_OPT_HI:`MR_OPT_LO];
  assign refresh_row  = row_reg;
  assign column_addr  = col_reg;
  assign suspended    = (st_reg == dev_suspend);
  assign dev_state    = st_reg;
  assign bank_open    = {bank_reg[1] != bank_idle, bank_reg[0] != bank_idle};
  assign illegal_cmd  = ill_reg;
endmodule

// [verilog/sdram_ctrl_end.sv]
// Purpose: Controller end: power-up sequence and timed command issue
// Assumes: One request at a time; req_cmd held until req_ready
// Notes:   Enforces act-to-act, act-to-column, row-active and mode waits
`timescale 1ns/1ps
`include "sdram_ctl_defines.svh"
module sdram_ctrl_end
  import sdram_ctl_pkg::*;
#(
  parameter int INIT_CYC = `T_INIT_CYC
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  sdram_link_if.ctrl         link,
  input  wire logic          req_valid,
  input  wire sdram_ctl_pkg::cmd_t req_cmd,
  input  wire logic [11:0]   req_addr,
  input  wire logic          req_cke,
  output      logic          req_ready,
  output      logic          init_done
);
  import sdram_ctl_pkg::*;

  typedef enum logic [2:0] {
    c_wait = 3'b000, c_pre = 3'b001, c_ref = 3'b011, c_load = 3'b010, c_run = 3'b110
  } cst_t;

  cst_t          st_reg, st_next;
  logic [15:0]   cnt_reg, cnt_next;
  logic [1:0]    nref_reg, nref_next;
  logic [3:0]    gap_reg, gap_next;
  logic [3:0]    rrd_reg, rrd_next;
  logic [3:0]    rcd_reg [2], rcd_next [2];
  logic [3:0]    ras_reg [2], ras_next [2];
  logic [1:0]    open_reg, open_next;
  logic [2:0]    bl_reg, bl_next;
  cmd_t          out_cmd_reg, out_cmd_next;
  logic [11:0]   addr_reg, addr_next;
  logic          cke_reg, cke_next;
  logic          ok;
  logic          s;

  assign s = req_addr[`BANK_BIT];

  always_comb begin
    ok = (gap_reg == 4'h0);
    case (req_cmd)
      cmd_act:   ok = ok && !open_reg[s] && rrd_reg == 4'h0;
      cmd_read, cmd_write: ok = ok && open_reg[s] && rcd_reg[s] == 4'h0;
      cmd_pre:   ok = ok && (req_addr[`AP_BIT] ? (ras_reg[0] == 4'h0 && ras_reg[1] == 4'h0)
                                          : ras_reg[s] == 4'h0);
      cmd_load, cmd_refresh: ok = ok && open_reg == 2'b00;
      cmd_burst_stop: ok = ok && bl_reg == `BL_FULL_PAGE;
      default: ;
    endcase
  end

  assign req_ready = (st_reg == c_run) && ok;
  assign init_done = (st_reg == c_run);

  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    nref_next    = nref_reg;
    gap_next     = (gap_reg != 4'h0) ? gap_reg - 4'h1 : 4'h0;
    rrd_next     = (rrd_reg != 4'h0) ? rrd_reg - 4'h1 : 4'h0;
    rcd_next     = rcd_reg;
    ras_next     = ras_reg;
    for (int b = 0; b < 2; b++) begin
      if (rcd_reg[b] != 4'h0) rcd_next[b] = rcd_reg[b] - 4'h1;
      if (ras_reg[b] != 4'h0) ras_next[b] = ras_reg[b] - 4'h1;
    end
    open_next    = open_reg;
    bl_next      = bl_reg;
    out_cmd_next = cmd_nop;
    addr_next    = addr_reg;
    cke_next     = cke_reg;
    case (st_reg)
      c_wait: begin
        cke_next = 1'b1;
        if (cnt_reg >= 16'(INIT_CYC - 1))
          st_next = c_pre;
        else
          cnt_next = cnt_reg + 16'h0001;
      end
      c_pre: begin
        out_cmd_next = cmd_pre;
        addr_next    = `PALL_ADDR;
        gap_next     = 4'(`T_RC_CYC);
        st_next      = c_ref;
      end
      c_ref: begin
        if (gap_reg == 4'h0) begin
          out_cmd_next = cmd_refresh;
          gap_next     = 4'(`T_RC_CYC);
          nref_next    = nref_reg + 2'h1;
          if (nref_reg == 2'(`REFRESH_INIT - 1))
            st_next = c_load;
        end
      end
      c_load: begin
        if (gap_reg == 4'h0) begin
          out_cmd_next = cmd_load;
          addr_next    = `INIT_MODE;
          bl_next      = 3'h0;
          gap_next     = 4'(`T_MRD_CYC);
          st_next      = c_run;
        end
      end
      c_run: begin
        cke_next = req_cke;
        if (req_valid && ok) begin
          out_cmd_next = req_cmd;
          addr_next    = req_addr;
          case (req_cmd)
            cmd_act: begin
              open_next[s] = 1'b1;
              rrd_next     = 4'(`T_RRD_CYC - 1);
              rcd_next[s]  = 4'(`T_RCD_CYC - 1);
              ras_next[s]  = 4'(`T_RAS_CYC - 1);
            end
            cmd_pre: begin
              if (req_addr[`AP_BIT]) open_next = 2'b00;
              else open_next[s] = 1'b0;
            end
            cmd_read, cmd_write: if (req_addr[`AP_BIT]) open_next[s] = 1'b0;
            cmd_load: begin
              bl_next  = req_addr[`MR_BL_HI:`MR_BL_LO];
              gap_next = 4'(`T_MRD_CYC);
            end
            cmd_refresh: gap_next = 4'(`T_RC_CYC);
            default: ;
          endcase
        end
      end
      default: st_next = c_wait;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg      <= c_wait;
      cnt_reg     <= 16'h0000;
      nref_reg    <= 2'h0;
      gap_reg     <= 4'h0;
      rrd_reg     <= 4'h0;
      rcd_reg[0]  <= 4'h0;
      rcd_reg[1]  <= 4'h0;
      ras_reg[0]  <= 4'h0;
      ras_reg[1]  <= 4'h0;
      open_reg    <= 2'b00;
      bl_reg      <= 3'h0;
      out_cmd_reg <= cmd_desel;
      addr_reg    <= 12'h000;
      cke_reg     <= 1'b1;
    end else begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      nref_reg    <= nref_next;
      gap_reg     <= gap_next;
      rrd_reg     <= rrd_next;
      rcd_reg     <= rcd_next;
      ras_reg     <= ras_next;
      open_reg    <= open_next;
      bl_reg      <= bl_next;
      out_cmd_reg <= out_cmd_next;
      addr_reg    <= addr_next;
      cke_reg     <= cke_next;
    end
  end

  // Byte masks held high; data path is outside this block
  assign link.cke   = cke_reg;
  assign link.cs_n  = out_cmd_reg[3];
  assign link.ras_n = out_cmd_reg[2];
  assign link.cas_n = out_cmd_reg[1];
  assign link.we_n  = out_cmd_reg[0];
  assign link.addr  = addr_reg;
  assign link.dqm   = 2'b11;
endmodule

// [verif/sdram_link_properties.sv]
// Purpose: Concurrent checks on the controller/device link
// Assumes: One clock; device outputs follow the link by one cycle
// Notes:   Instantiated beside the link interface, no bind
`timescale 1ns/1ps
`include "sdram_ctl_defines.svh"
module sdram_link_properties
  import sdram_ctl_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      cke,
  input wire logic                      cs_n,
  input wire logic                      ras_n,
  input wire logic                      cas_n,
  input wire logic                      we_n,
  input wire logic [11:0]               addr,
  input wire logic [2:0]                burst_len,
  input wire logic                      burst_type,
  input wire logic [2:0]                read_latency,
  input wire logic [3:0]                mode_options,
  input wire logic                      suspended,
  input wire sdram_ctl_pkg::dev_state_t dev_state,
  input wire logic [1:0]                bank_open
);
  logic [3:0] cmd;
  // Any deselect folds to 8 so nop and deselect compare as >= 7
  assign cmd = cs_n ? 4'h8 : {1'b0, ras_n, cas_n, we_n};
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence idle_run;
    dev_state == dev_idle && bank_open == 2'b00 && cke && $past(cke);
  endsequence
  sequence idle_drop;
    dev_state == dev_idle && bank_open == 2'b00 && $past(cke) && !cke;
  endsequence
  sequence recov_run;
    dev_state == dev_sr_recov && $past(dev_state) == dev_self_ref ##1 (cke && cmd >= 4'h7)[*4];
  endsequence
  chk_mode_capture: assert property (idle_run ##0 cmd == 4'h0 |=>
    {mode_options, read_latency, burst_type, burst_len} == {$past(addr[11:8]), $past(addr[6:0])})
    else $error("mode fields differ from loaded code");
  chk_act_opens: assert property (idle_run ##0 cmd == 4'h3 |=>
    bank_open == ($past(addr[11]) ? 2'b10 : 2'b01)) else $error("activate opened wrong bank");
  chk_pdown_entry: assert property (idle_drop ##0 cmd != 4'h1 |=> dev_state == dev_pdown)
    else $error("no power-down entry");
  chk_selfref_entry: assert property (idle_drop ##0 cmd == 4'h1 |=> dev_state == dev_self_ref)
    else $error("no self-refresh entry");
  chk_pdown_hold: assert property (dev_state == dev_pdown && !cke |=>
    dev_state == dev_pdown && $stable(bank_open)) else $error("power-down left early");
  chk_pdown_exit: assert property (dev_state == dev_pdown && cke |=> dev_state == dev_idle)
    else $error("power-down not ended by gate");
  chk_selfref_hold: assert property (dev_state == dev_self_ref && !cke |=>
    dev_state == dev_self_ref && $stable({bank_open, burst_len})) else $error("self-refresh left");
  chk_selfref_exit: assert property (dev_state == dev_self_ref && cke |=>
    dev_state == dev_sr_recov) else $error("no recovery after self-refresh");
  chk_recov_time: assert property (recov_run |=> dev_state == dev_idle)
    else $error("recovery did not reach idle");
  chk_recov_pdown: assert property (dev_state == dev_sr_recov && $past(cke) && !cke
    && cmd >= 4'h7 |=> dev_state == dev_pdown) else $error("recovery ignored gate drop");
  chk_clock_suspend: assert property (bank_open != 2'b00 && $past(cke) && !cke |=> suspended)
    else $error("clock not suspended");
  chk_suspend_end: assert property (suspended && cke |=> !suspended)
    else $error("suspension not ended");
  logic [3:0] since_act [2];
  // Saturating count of cycles since each bank's activate, so old rows never look fresh
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      since_act[0] <= 4'hf;
      since_act[1] <= 4'hf;
    end else begin
      for (int b = 0; b < 2; b++)
        if (cmd == 4'h3 && addr[`BANK_BIT] == b[0])
          since_act[b] <= 4'h1;
        else if (since_act[b] != 4'hf)
          since_act[b] <= since_act[b] + 4'h1;
    end
  end
  chk_row_spacing: assert property (cmd inside {4'h4, 4'h5} |->
    since_act[addr[`BANK_BIT]] >= 4'(`T_RCD_CYC)) else $error("column too soon after activate");
  chk_ras_spacing: assert property (cmd == 4'h2 |->
    (addr[`AP_BIT] ? (since_act[0] >= 4'(`T_RAS_CYC) && since_act[1] >= 4'(`T_RAS_CYC))
                   : since_act[addr[`BANK_BIT]] >= 4'(`T_RAS_CYC)))
    else $error("precharge too soon after activate");
  chk_mode_wait: assert property (cmd == 4'h0 |=> cmd >= 4'h7)
    else $error("command too soon after mode load");
  chk_stop_page: assert property (cmd == 4'h6 |-> burst_len == `BL_FULL_PAGE)
    else $error("burst stop without full page");
endmodule

// [verif/tb_sdram_clock_enable_power_ctl.sv]
// Purpose: Self-checking bench joining both link ends
// Assumes: Short init count; results follow requests within a few cycles
// Notes:   Notes queue is compared at falling edges, when outputs settle
`timescale 1ns/1ps
`include "sdram_ctl_defines.svh"
module tb_sdram_clock_enable_power_ctl;
  import sdram_ctl_pkg::*;
  typedef struct {string name; int sel; logic [11:0] exp;} note_t;
  logic       mclk, rst, req_valid, req_cke, req_ready, init_done;
  logic       suspended, burst_type, illegal_cmd;
  cmd_t       req_cmd;
  logic [11:0] req_addr, v;
  logic [2:0] burst_len, read_latency;
  logic [3:0] mode_options;
  logic [10:0] refresh_row;
  logic [7:0] column_addr;
  logic [1:0] bank_open;
  dev_state_t dev_state;
  note_t      notes[$];
  int         n_mismatch, samples_checked, seed;
  sdram_link_if link ();
  sdram_ctrl_end #(.INIT_CYC(10)) sdram_ctrl_end_i (.mclk(mclk), .rst(rst), .link(link),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_cke(req_cke),
    .req_ready(req_ready), .init_done(init_done));
  sdram_dev_end sdram_dev_end_i (.mclk(mclk), .rst(rst), .link(link), .burst_len(burst_len),
    .burst_type(burst_type), .read_latency(read_latency), .mode_options(mode_options),
    .refresh_row(refresh_row), .column_addr(column_addr), .suspended(suspended),
    .dev_state(dev_state), .bank_open(bank_open), .illegal_cmd(illegal_cmd));
  sdram_link_properties sdram_link_properties_i (.mclk(mclk), .rst(rst), .cke(link.cke),
    .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .addr(link.addr), .burst_len(burst_len), .burst_type(burst_type),
    .read_latency(read_latency), .mode_options(mode_options), .suspended(suspended),
    .dev_state(dev_state), .bank_open(bank_open));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [11:0] seen(int sel);
    case (sel)
      0: seen = {9'h000, dev_state};
      1: seen = {10'h000, bank_open};
      2: seen = {9'h000, read_latency};
      3: seen = {4'h0, column_addr};
      4: seen = {1'b0, refresh_row};
      5: seen = {11'h000, suspended};
      6: seen = {11'h000, req_ready};
      8: seen = {11'h000, illegal_cmd};
      default: seen = {mode_options, 1'b0, read_latency, burst_type, burst_len};
    endcase
  endfunction
  always @(negedge mclk) begin
    if (notes.size() > 0) begin
      samples_checked++;
      if (seen(notes[0].sel) !== notes[0].exp) begin
        n_mismatch++;
        $display("unexpected %s: expected %h seen %h", notes[0].name, notes[0].exp,
          seen(notes[0].sel));
      end
      void'(notes.pop_front());
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic note(string name, int sel, logic [11:0] exp, int d);
    repeat (d) @(posedge mclk);
    notes.push_back('{name, sel, exp});
  endtask
  task automatic issue(cmd_t c, logic [11:0] a, logic k);
    int i;
    i = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_cke <= k;
    // Request held until the edge that samples ready high
    do begin
      @(posedge mclk);
      i++;
    end while (req_ready !== 1'b1 && i < 200);
    req_valid <= 1'b0;
    if (i >= 200) begin
      n_mismatch++;
      $display("unexpected req_ready for %s: expected 1 seen 0", c.name());
      results();
    end
  endtask
  task automatic refuse(cmd_t c, logic [11:0] a);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    repeat (6) note("req_ready", 6, 12'h000, 1);
    req_valid <= 1'b0;
  endtask
  task automatic set_cke(logic k);
    @(posedge mclk);
    req_cke <= k;
  endtask
  initial begin
    seed = 32'hc474;
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = cmd_nop;
    req_addr = 12'h000;
    req_cke = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 500 && init_done !== 1'b1; i++) @(posedge mclk);
    if (init_done !== 1'b1) begin
      n_mismatch++;
      $display("unexpected init_done: expected 1 seen %b", init_done);
      results();
    end
    note("read_latency", 2, 12'h002, 1);
    note("refresh_row", 4, 12'h002, 0);
    note("illegal_cmd", 8, 12'h000, 0);
    $display("test init done");
    v = 12'($random(seed));
    v[2:0] = 3'h1;
    issue(cmd_load, v, 1'b1);
    note("mode fields", 7, {v[11:8], 1'b0, v[6:0]}, 3);
    refuse(cmd_burst_stop, 12'h000);
    issue(cmd_refresh, 12'hfff, 1'b1);
    note("refresh_row", 4, 12'h003, 4);
    $display("test mode and refresh done");
    issue(cmd_act, {1'b0, 11'($random(seed))}, 1'b1);
    note("bank_open", 1, 12'h001, 3);
    refuse(cmd_act, 12'h000);
    refuse(cmd_read, 12'h800);
    v = {4'h3, 8'($random(seed))};
    issue(cmd_write, v, 1'b1);
    note("column_addr", 3, {4'h0, v[7:0]}, 3);
    issue(cmd_act, {1'b1, 11'($random(seed))}, 1'b1);
    issue(cmd_read, 12'hc05, 1'b1);
    note("bank_open", 1, 12'h001, 10);
    $display("test banks done");
    set_cke(1'b0);
    note("suspended", 5, 12'h001, 4);
    set_cke(1'b1);
    note("suspended", 5, 12'h000, 4);
    issue(cmd_pre, 12'h400, 1'b1);
    note("bank_open", 1, 12'h000, 4);
    $display("test suspend done");
    set_cke(1'b0);
    note("dev_state", 0, {9'h000, dev_pdown}, 4);
    note("dev_state", 0, {9'h000, dev_pdown}, 5);
    set_cke(1'b1);
    note("dev_state", 0, {9'h000, dev_idle}, 4);
    issue(cmd_refresh, 12'h000, 1'b0);
    note("dev_state", 0, {9'h000, dev_self_ref}, 3);
    note("dev_state", 0, {9'h000, dev_self_ref}, 5);
    set_cke(1'b1);
    // A refresh during recovery is flagged but must not stall the return to idle
    issue(cmd_refresh, 12'h000, 1'b1);
    note("illegal_cmd", 8, 12'h001, 1);
    note("dev_state", 0, {9'h000, dev_idle}, 10);
    issue(cmd_refresh, 12'h000, 1'b0);
    note("dev_state", 0, {9'h000, dev_self_ref}, 3);
    set_cke(1'b1);
    set_cke(1'b0);
    note("dev_state", 0, {9'h000, dev_pdown}, 5);
    set_cke(1'b1);
    note("dev_state", 0, {9'h000, dev_idle}, 4);
    repeat (3) @(posedge mclk);
    $display("test power modes done");
    results();
  end
endmodule
